/* File: prcs_consts.svh */
// Register offsets, field positions, reset values and counts of the clock switchover
`ifndef PRCS_CONSTS_SVH
`define PRCS_CONSTS_SVH
`define PRCS_ADDR_W 8
`define PRCS_DATA_W 32
`define PRCS_CNT_W 8
`define PRCS_OFF_CTRL 8'h00
`define PRCS_OFF_DELAY 8'h04
`define PRCS_OFF_LOSS 8'h08
`define PRCS_OFF_STATUS 8'h0c
`define PRCS_OFF_CAL0 8'h10
`define PRCS_OFF_CAL1 8'h14
`define PRCS_CAL_SEL_BIT 2
`define PRCS_F_MODE 1:0
`define PRCS_MIN_LOW 8'h03
`define PRCS_RST_MODE 2'h0
`define PRCS_RST_DELAY 8'h00
`define PRCS_RST_LOSS 8'h10
`define PRCS_RESP_OK 2'h0
`define PRCS_RESP_ERR 2'h2
`endif

/* File: prcs_pkg.sv */
// Types shared by the clock switchover block
`include "prcs_consts.svh"
package prcs_pkg;
   typedef enum logic [1:0] {PRCS_MANUAL, PRCS_AUTO, PRCS_AUTO_OVR} prcs_mode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_GATE, ST_SWITCH} prcs_fsm_t;
   typedef struct packed {
      logic awvalid;
      logic [`PRCS_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [`PRCS_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`PRCS_ADDR_W-1:0] araddr;
      logic rready;
   } prcs_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`PRCS_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } prcs_axi_rsp_t;
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic armed;
      logic [`PRCS_CNT_W-1:0] low_cnt;
      logic [1:0] clk_q;
      logic [1:0][`PRCS_CNT_W-1:0] idle;
      logic [1:0] lost;
      logic sel;
      logic gate_open;
      prcs_fsm_t fsm;
      logic clk_out;
      logic [1:0] mode;
      logic [`PRCS_CNT_W-1:0] delay;
      logic [`PRCS_CNT_W-1:0] loss_to;
      logic aw_got;
      logic w_got;
      logic [`PRCS_ADDR_W-1:0] aw_addr;
      logic [`PRCS_DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rd_pend;
      logic [`PRCS_ADDR_W-1:0] rd_addr;
      logic rvalid;
      logic [`PRCS_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } prcs_state_t;
endpackage : prcs_pkg

/* File: prcs_cal_mem.sv */
// Small calibration store, one word per reference input, registered read ports
`timescale 1ns/10ps
module prcs_cal_mem #(
   parameter int W = 32,
   parameter int D = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Byte-enabled write port
   input wire logic we,
   input wire logic [$clog2(D)-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [W/8-1:0] wstrb,
   // Registered read ports
   input wire logic [$clog2(D)-1:0] raddr_a,
   output logic [W-1:0] rdata_a,
   input wire logic [$clog2(D)-1:0] raddr_b,
   output logic [W-1:0] rdata_b
);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [W-1:0] rd_a;
      logic [W-1:0] rd_b;
   } prcs_mem_state_t;
   prcs_mem_state_t r;
   prcs_mem_state_t n;

   if (D < 2 || W % 8 != 0) begin : g_chk
      $error("prcs_cal_mem: depth below 2 or width not whole bytes");
   end

   always_comb begin
      n = r;
      for (int b = 0; b < W / 8; b++) begin
         if (we && wstrb[b]) begin
            n.mem[waddr][b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      n.rd_a = r.mem[raddr_a];
      n.rd_b = r.mem[raddr_b];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rdata_a = r.rd_a;
   assign rdata_b = r.rd_b;
endmodule : prcs_cal_mem

/* File: prcs_switchover.sv */
// Reference clock switchover for a PLL, with AXI4-Lite control and status
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "prcs_consts.svh"
module prcs_switchover #(
   parameter int DELAY_MAX = 200
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire prcs_pkg::prcs_axi_req_t axi_req,
   output prcs_pkg::prcs_axi_rsp_t axi_rsp,
   // Reference clocks and switch request
   input wire logic ref_clock_primary,
   input wire logic ref_clock_backup,
   input wire logic switch_req_n,
   // Toward the PLL and the fabric
   output logic ref_clock_out,
   output logic active_clock,
   output logic primary_lost_flag,
   output logic backup_lost_flag,
   output logic [`PRCS_DATA_W-1:0] cal_word
);
   import prcs_pkg::*;

   localparam int CW = `PRCS_CNT_W;

   if (DELAY_MAX < 0 || DELAY_MAX + 3 >= (1 << CW) - 1) begin : g_chk
      $error("prcs_switchover: DELAY_MAX does not fit the low-time counter");
   end

   prcs_state_t r;
   prcs_state_t n;
   logic [1:0] clk_in;
   logic [1:0] fall;
   logic cur_fall;
   logic tgt_fall;
   logic [CW:0] threshold;
   logic man_trig;
   logic auto_trig;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic [`PRCS_ADDR_W-1:0] waddr;
   logic [`PRCS_DATA_W-1:0] wdat;
   logic [3:0] wstr;
   logic mem_we;
   logic [`PRCS_DATA_W-1:0] mem_rdata;

   // ******************************************************
   // Decode helpers
   // ******************************************************
   function automatic logic is_mapped(input logic [`PRCS_ADDR_W-1:0] a);
      return a == `PRCS_OFF_CTRL || a == `PRCS_OFF_DELAY || a == `PRCS_OFF_LOSS ||
             a == `PRCS_OFF_STATUS || a == `PRCS_OFF_CAL0 || a == `PRCS_OFF_CAL1;
   endfunction : is_mapped

   // Unused mode code 3 falls back to manual
   function automatic logic man_en(input logic [1:0] m);
      return m != PRCS_AUTO;
   endfunction : man_en

   function automatic logic auto_en(input logic [1:0] m);
      return m == PRCS_AUTO || m == PRCS_AUTO_OVR;
   endfunction : auto_en

   function automatic logic ovr_en(input logic [1:0] m);
      return m == PRCS_AUTO_OVR;
   endfunction : ovr_en

   function automatic logic [CW-1:0] clamp_delay(input logic [7:0] v);
      return (int'(v) > DELAY_MAX) ? CW'(DELAY_MAX) : CW'(v);
   endfunction : clamp_delay

   // ******************************************************
   // Next-state logic
   // ******************************************************
   always_comb begin
      n = r;
      clk_in = {ref_clock_backup, ref_clock_primary};
      n.req_s1 = switch_req_n;
      n.req_s2 = r.req_s1;

      // Clock sense: count idle cycles since the last edge of each input
      for (int i = 0; i < 2; i++) begin
         fall[i] = r.clk_q[i] & ~clk_in[i];
         n.clk_q[i] = clk_in[i];
         if (r.clk_q[i] != clk_in[i]) begin
            n.idle[i] = '0;
            n.lost[i] = 1'b0;
         end else begin
            if (r.idle[i] != '1) begin
               n.idle[i] = r.idle[i] + 1'b1;
            end
            if (r.idle[i] >= r.loss_to) begin
               n.lost[i] = 1'b1;
            end
         end
      end
      cur_fall = fall[r.sel];
      tgt_fall = fall[~r.sel];

      // Manual request: armed while high, counts target falls while low
      threshold = {1'b0, `PRCS_MIN_LOW} + {1'b0, r.delay};
      man_trig = 1'b0;
      if (r.req_s2) begin
         n.armed = 1'b1;
         n.low_cnt = '0;
      end else if (r.armed && man_en(r.mode)) begin
         if (tgt_fall && r.low_cnt != '1) begin
            n.low_cnt = r.low_cnt + 1'b1;
         end
         if ({1'b0, r.low_cnt} >= threshold && r.fsm == ST_IDLE) begin
            man_trig = 1'b1;
            n.armed = 1'b0;
         end
      end

      // Automatic switch needs a live target input; blocked by a low request in override
      auto_trig = auto_en(r.mode) && r.lost[r.sel] && !r.lost[~r.sel] &&
                  !(ovr_en(r.mode) && !r.req_s2) &&
                  r.fsm == ST_IDLE && !man_trig;

      unique case (r.fsm)
         ST_IDLE: begin
            if (man_trig || auto_trig) begin
               n.fsm = ST_GATE;
            end
         end
         ST_GATE: begin
            // A dead current clock will never fall, so gate at once
            if (cur_fall || r.lost[r.sel]) begin
               n.gate_open = 1'b0;
               n.fsm = ST_SWITCH;
            end
         end
         ST_SWITCH: begin
            if (tgt_fall) begin
               n.sel = ~r.sel;
               n.gate_open = 1'b1;
               n.fsm = ST_IDLE;
            end
         end
         default: begin
            n.fsm = ST_IDLE;
         end
      endcase
      n.clk_out = n.gate_open ? clk_in[n.sel] : 1'b0;

      // ******************************************************
      // AXI4-Lite slave
      // ******************************************************
      aw_hs = axi_req.awvalid && !r.aw_got && !r.bvalid;
      w_hs = axi_req.wvalid && !r.w_got && !r.bvalid;
      waddr = r.aw_got ? r.aw_addr : axi_req.awaddr;
      wdat = r.w_got ? r.w_data : axi_req.wdata;
      wstr = r.w_got ? r.w_strb : axi_req.wstrb;
      mem_we = 1'b0;
      if (r.bvalid && axi_req.bready) begin
         n.bvalid = 1'b0;
      end
      if (aw_hs) begin
         n.aw_got = 1'b1;
         n.aw_addr = axi_req.awaddr;
      end
      if (w_hs) begin
         n.w_got = 1'b1;
         n.w_data = axi_req.wdata;
         n.w_strb = axi_req.wstrb;
      end
      if ((r.aw_got || aw_hs) && (r.w_got || w_hs)) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = is_mapped(waddr) ? `PRCS_RESP_OK : `PRCS_RESP_ERR;
         if (wstr[0]) begin
            if (waddr == `PRCS_OFF_CTRL) begin
               n.mode = wdat[`PRCS_F_MODE];
            end
            if (waddr == `PRCS_OFF_DELAY) begin
               n.delay = clamp_delay(wdat[7:0]);
            end
            if (waddr == `PRCS_OFF_LOSS) begin
               n.loss_to = wdat[CW-1:0];
            end
         end
         mem_we = waddr == `PRCS_OFF_CAL0 || waddr == `PRCS_OFF_CAL1;
      end

      // Reads take two cycles so calibration words come from the memory register
      ar_hs = axi_req.arvalid && !r.rd_pend && !r.rvalid;
      if (r.rvalid && axi_req.rready) begin
         n.rvalid = 1'b0;
      end
      n.rd_pend = ar_hs;
      if (ar_hs) begin
         n.rd_addr = axi_req.araddr;
      end
      if (r.rd_pend) begin
         n.rvalid = 1'b1;
         n.rresp = is_mapped(r.rd_addr) ? `PRCS_RESP_OK : `PRCS_RESP_ERR;
         n.rdata = '0;
         if (r.rd_addr == `PRCS_OFF_CTRL) begin
            n.rdata[`PRCS_F_MODE] = r.mode;
         end
         if (r.rd_addr == `PRCS_OFF_DELAY) begin
            n.rdata[CW-1:0] = r.delay;
         end
         if (r.rd_addr == `PRCS_OFF_LOSS) begin
            n.rdata[CW-1:0] = r.loss_to;
         end
         if (r.rd_addr == `PRCS_OFF_STATUS) begin
            n.rdata[7:0] = {r.req_s2, r.armed, r.fsm, r.lost, r.gate_open, r.sel};
         end
         if (r.rd_addr == `PRCS_OFF_CAL0 || r.rd_addr == `PRCS_OFF_CAL1) begin
            n.rdata = mem_rdata;
         end
      end
   end

   // ******************************************************
   // State register
   // ******************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.req_s1 <= 1'b1;
         r.req_s2 <= 1'b1;
         r.gate_open <= 1'b1;
         r.mode <= `PRCS_RST_MODE;
         r.delay <= `PRCS_RST_DELAY;
         r.loss_to <= `PRCS_RST_LOSS;
      end else begin
         r <= n;
      end
   end

   // Calibration word for each input; the selected one follows the switch
   prcs_cal_mem #(
      .W(`PRCS_DATA_W),
      .D(2)
   ) u_cal_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(mem_we),
      .waddr(waddr[`PRCS_CAL_SEL_BIT]),
      .wdata(wdat),
      .wstrb(wstr),
      .raddr_a(axi_req.araddr[`PRCS_CAL_SEL_BIT]),
      .rdata_a(mem_rdata),
      .raddr_b(r.sel),
      .rdata_b(cal_word)
   );

   // ******************************************************
   // Outputs
   // ******************************************************
   assign axi_rsp.awready = !r.aw_got && !r.bvalid;
   assign axi_rsp.wready = !r.w_got && !r.bvalid;
   assign axi_rsp.bvalid = r.bvalid;
   assign axi_rsp.bresp = r.bresp;
   assign axi_rsp.arready = !r.rd_pend && !r.rvalid;
   assign axi_rsp.rvalid = r.rvalid;
   assign axi_rsp.rdata = r.rdata;
   assign axi_rsp.rresp = r.rresp;
   assign ref_clock_out = r.clk_out;
   assign active_clock = r.sel;
   assign primary_lost_flag = r.lost[0];
   assign backup_lost_flag = r.lost[1];

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_gate_cause;
      $past(r.fsm) == ST_GATE && ($past(cur_fall) || $past(r.lost[r.sel]));
   endsequence
   sequence s_switch_cause;
      $past(r.fsm) == ST_SWITCH && $past(tgt_fall) && !$past(r.gate_open);
   endsequence

   property p_gate_on_fall;
      $fell(r.gate_open) |-> s_gate_cause;
   endproperty
   a_gate_on_fall: assert property (p_gate_on_fall) else $error("gate off edge");

   property p_sel_after_gate;
      $changed(r.sel) |-> s_switch_cause ##0 r.gate_open;
   endproperty
   a_sel_after_gate: assert property (p_sel_after_gate) else $error("bad mux move");

   property p_out_quiet;
      !r.gate_open |-> !r.clk_out;
   endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("gated clock leaks");

   property p_reset_primary;
      !$past(aresetn) |-> !r.sel && r.gate_open;
   endproperty
   a_reset_primary: assert property (p_reset_primary) else $error("not primary");

   property p_min_low;
      man_trig |-> !r.req_s2 && !$past(r.req_s2) && !$past(r.req_s2, 2) && !$past(r.req_s2, 3);
   endproperty
   a_min_low: assert property (p_min_low) else $error("switch on short request");

   property p_rise_inert;
      $rose(r.req_s2) |-> !man_trig [*3];
   endproperty
   a_rise_inert: assert property (p_rise_inert) else $error("rise switched");

   property p_flag_clear;
      $changed(r.clk_q[0]) ##0 $changed(r.clk_q[1]) |-> !r.lost[0] && !r.lost[1];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag on live clock");

   property p_auto_go;
      auto_trig |=> r.fsm == ST_GATE ##1 r.fsm != ST_IDLE;
   endproperty
   a_auto_go: assert property (p_auto_go) else $error("auto switch not started");

   property p_ovr_block;
      ovr_en(r.mode) && !r.req_s2 && r.fsm == ST_IDLE && !man_trig |=> r.fsm == ST_IDLE;
   endproperty
   a_ovr_block: assert property (p_ovr_block) else $error("override did not block");

   property p_wait_target;
      r.fsm == ST_SWITCH && !tgt_fall |=> r.fsm == ST_SWITCH && $stable(r.sel);
   endproperty
   a_wait_target: assert property (p_wait_target) else $error("dead target taken");
endmodule : prcs_switchover

/* File: prcs_ref_src.sv */
// Model of the two reference oscillators that feed the switchover block
`timescale 1ns/10ps
module prcs_ref_src #(
   parameter int HALF_P = 40,
   parameter int HALF_B = 50
) (
   // Oscillator enables
   input wire logic run_p,
   input wire logic run_b,
   // Reference clocks
   output logic ref_p,
   output logic ref_b
);
   // ****************************************
   // Oscillators
   // ****************************************
   // A stopped source parks low, as a dead oscillator would
   initial begin
      ref_p = 1'b0;
      forever begin
         #HALF_P;
         ref_p = run_p ? ~ref_p : 1'b0;
      end
   end

   // Offset start keeps the two sources unrelated in phase and off the aclk edges
   initial begin
      ref_b = 1'b0;
      #7;
      forever begin
         #HALF_B;
         ref_b = run_b ? ~ref_b : 1'b0;
      end
   end
endmodule : prcs_ref_src

/* File: tb_pll_ref_clock_switchover.sv */
// Self-checking testbench of the reference clock switchover block
`timescale 1ns/10ps
`include "prcs_consts.svh"
module tb_pll_ref_clock_switchover;
   import prcs_pkg::*;
   logic aclk;
   logic aresetn;
   logic switch_req_n;
   logic run_p;
   logic run_b;
   logic ref_p;
   logic ref_b;
   logic ref_clock_out;
   logic active_clock;
   logic primary_lost_flag;
   logic backup_lost_flag;
   logic [`PRCS_DATA_W-1:0] cal_word;
   prcs_axi_req_t req;
   prcs_axi_rsp_t rsp;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic [1:0] rr;
   logic [1:0] br;

   prcs_switchover i_dut (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .ref_clock_primary(ref_p), .ref_clock_backup(ref_b), .switch_req_n(switch_req_n),
      .ref_clock_out(ref_clock_out), .active_clock(active_clock),
      .primary_lost_flag(primary_lost_flag), .backup_lost_flag(backup_lost_flag),
      .cal_word(cal_word)
   );

   prcs_ref_src i_src (.run_p(run_p), .run_b(run_b), .ref_p(ref_p), .ref_b(ref_b));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic give_up(input string msg);
      err_total++;
      $display("mismatch at %0t: %s never finished", $time, msg);
      complete_run();
   endtask : give_up

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) break;
      end
      if (n == 50) give_up("write");
      br = rsp.bresp;
      req.bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rdreg(input logic [7:0] a);
      int n;
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) break;
      end
      if (n == 50) give_up("read");
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
      @(posedge aclk);
   endtask : rdreg

   task automatic wait_act(input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge aclk);
         if (active_clock === v) break;
      end
      if (n == lim) give_up("switchover");
   endtask : wait_act

   // Output is the selected input, one aclk late, once the gate has reopened
   task automatic chk_follow(input logic s);
      logic prev;
      prev = s ? ref_b : ref_p;
      repeat (20) begin
         @(posedge aclk);
         chk(32'(ref_clock_out), 32'(prev), "reference out");
         prev = s ? ref_b : ref_p;
      end
   endtask : chk_follow

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk(32'(active_clock), 32'h0, "active after reset");
      chk(32'({primary_lost_flag, backup_lost_flag}), 32'h0, "flags after reset");
      rdreg(`PRCS_OFF_CTRL);
      chk(rd, 32'(`PRCS_RST_MODE), "ctrl reset");
      rdreg(`PRCS_OFF_DELAY);
      chk(rd, 32'(`PRCS_RST_DELAY), "delay reset");
      rdreg(`PRCS_OFF_LOSS);
      chk(rd, 32'(`PRCS_RST_LOSS), "loss reset");
      rdreg(8'h18);
      chk(32'(rr), 32'(`PRCS_RESP_ERR), "unmapped read");
      wr(8'h18, 32'h0);
      chk(32'(br), 32'(`PRCS_RESP_ERR), "unmapped write");
   endtask : t_reset

   task automatic t_manual;
      wr(`PRCS_OFF_CAL0, 32'h1111_1111);
      chk(32'(br), 32'(`PRCS_RESP_OK), "cal write resp");
      wr(`PRCS_OFF_CAL1, 32'h2222_2222);
      switch_req_n <= 1'b0;
      wait_act(1'b1, 200);
      chk(32'({primary_lost_flag, backup_lost_flag}), 32'h0, "flags in manual");
      chk_follow(1'b1);
      cyc(2);
      chk(cal_word, 32'h2222_2222, "backup cal word");
      switch_req_n <= 1'b1;
      cyc(50);
      chk(32'(active_clock), 32'h1, "rising edge switched");
      switch_req_n <= 1'b0;
      wait_act(1'b0, 200);
      switch_req_n <= 1'b1;
      cyc(2);
      chk(cal_word, 32'h1111_1111, "primary cal word");
      cyc(10);
   endtask : t_manual

   task automatic t_short;
      switch_req_n <= 1'b0;
      cyc(12);
      switch_req_n <= 1'b1;
      cyc(100);
      chk(32'(active_clock), 32'h0, "short pulse switched");
   endtask : t_short

   task automatic t_delay;
      wr(`PRCS_OFF_DELAY, 32'h4);
      rdreg(`PRCS_OFF_DELAY);
      chk(rd, 32'h4, "delay readback");
      // Four target falls at most: enough without the delay, too few with it
      switch_req_n <= 1'b0;
      cyc(40);
      switch_req_n <= 1'b1;
      cyc(30);
      chk(32'(active_clock), 32'h0, "switched inside delay");
      switch_req_n <= 1'b0;
      wait_act(1'b1, 300);
      switch_req_n <= 1'b1;
      wr(`PRCS_OFF_DELAY, 32'h0);
      cyc(10);
   endtask : t_delay

   task automatic t_stopped;
      run_p <= 1'b0;
      cyc(30);
      switch_req_n <= 1'b0;
      cyc(150);
      chk(32'(active_clock), 32'h1, "switched to dead clock");
      chk(32'(primary_lost_flag), 32'h1, "primary lost flag");
      run_p <= 1'b1;
      wait_act(1'b0, 300);
      switch_req_n <= 1'b1;
      cyc(40);
      chk(32'(primary_lost_flag), 32'h0, "primary flag cleared");
   endtask : t_stopped

   task automatic t_auto;
      wr(`PRCS_OFF_CTRL, 32'h1);
      run_p <= 1'b0;
      wait_act(1'b1, 100);
      chk(32'(primary_lost_flag), 32'h1, "auto lost flag");
      run_p <= 1'b1;
      cyc(40);
   endtask : t_auto

   task automatic t_override;
      wr(`PRCS_OFF_CTRL, 32'h2);
      switch_req_n <= 1'b0;
      wait_act(1'b0, 300);
      chk_follow(1'b0);
      run_p <= 1'b0;
      cyc(100);
      chk(32'(active_clock), 32'h0, "auto switch while held");
      run_p <= 1'b1;
      cyc(40);
      switch_req_n <= 1'b1;
      cyc(10);
   endtask : t_override

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      req = '0;
      aresetn = 1'b0;
      switch_req_n = 1'b1;
      run_p = 1'b1;
      run_b = 1'b1;
      cyc(4);
      aresetn <= 1'b1;
      cyc(1);
      t_reset();
      t_manual();
      t_short();
      t_delay();
      t_stopped();
      t_auto();
      t_override();
      complete_run();
   end
endmodule : tb_pll_ref_clock_switchover
